// *** aer_pkg.sv ***
package aer_pkg;
   // register byte addresses
   localparam logic [11:0] OFS_UNC_SEVERITY = 12'h10c;
   localparam logic [11:0] OFS_COR_STATUS = 12'h110;
   localparam logic [11:0] OFS_UNC_MASK = 12'h104;
   localparam logic [11:0] OFS_COR_MASK = 12'h114;
   localparam logic [11:0] OFS_ERR_CTRL = 12'h118;
   localparam logic [11:0] OFS_UNC_STATUS = 12'h100;
   // severity layout: writable bits and reset value
   localparam logic [31:0] SEV_WR_MASK = 32'h003f3031;
   localparam logic [31:0] SEV_RESET = 32'h00062030;
   // correctable status bits
   localparam logic [31:0] COR_WR_MASK = 32'h000031c1;
   localparam logic [31:0] COR_MASK_RESET = 32'h00002000;
   // uncorrectable events that can occur
   localparam logic [31:0] UNC_WR_MASK = 32'h003f3030;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
   localparam logic [4:0] PTR_RESET = 5'h00;

   // one error report towards the root complex
   typedef struct packed {
      logic fatal;
      logic nonfatal;
      logic correctable;
   } aer_report_s;

   // register access from software
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } aer_bus_s;
endpackage

// *** aer_sticky_reg.sv ***
// sticky word; only the power-on reset clears it, hot reset leaves it
module aer_sticky_reg (
   // clock and power-on reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // control
   input wire logic [31:0] rst_val_i,
   input wire logic [31:0] d_i,
   input wire logic en_i,
   // value
   output logic [31:0] q_o
);
   logic [31:0] q_q;
   logic init_q;

   // reset takes a constant; the reset value is loaded on the first edge
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q_q <= 32'h00000000;
         init_q <= 1'b0;
      end else if (!init_q) begin
         q_q <= rst_val_i;
         init_q <= 1'b1;
      end else if (en_i) begin
         q_q <= d_i;
      end
   end

   assign q_o = q_q;
endmodule

// *** aer_severity_and_correctable_status.sv ***
// Behaviour
// - unmasked uncorrectable event uses its severity bit to pick the report class
// - severity bit one reports the event as fatal
// - severity bit zero reports the event as non-fatal
// - masked uncorrectable events produce no report
// - bits 4,5,13,17,18 are sticky read-write, reset to one
// - bits 12,16,19,20,21 are sticky read-write, reset to zero
// - completion timeout severity bit 14 reads zero always
// - completer abort severity bit 15 reads zero always
// - severity bit 0 is sticky storage, resets zero, no effect
// - receiver error sets status bit 0, write one clears
// - bad transaction packet sets status bit 6, write one clears
// - bad link packet sets status bit 7, write one clears
// - replay rollover sets status bit 8, write one clears
// - replay timer expiry sets status bit 12, write one clears
// - advisory non-fatal error sets status bit 13, write one clears
// - masked correctable event sets status but sends no report
// - masked uncorrectable event still sets its status bit, no pointer update, no report
// - five-bit sticky pointer holds bit of first reported error
module aer_severity_and_correctable_status (
   // clock and power-on reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // hot or link reset, synchronous, clears nothing sticky
   input wire logic hot_reset_i,
   // register port
   input wire logic [11:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // error events, one-cycle pulses from link logic
   input wire logic [31:0] unc_event_i,
   input wire logic [31:0] cor_event_i,
   // reports to the root complex, one-cycle pulses
   output logic rep_fatal_o,
   output logic rep_nonfatal_o,
   output logic rep_correctable_o
);
   aer_pkg::aer_bus_s bus;
   aer_pkg::aer_report_s rep_q;
   logic [31:0] sev_q, sev_d;
   logic sev_en;
   logic [31:0] cor_q, cor_d, cormask_q, uncmask_q, uncst_q;
   logic [4:0] ptr_q;
   logic ptr_valid_q;
   logic [31:0] unc_live, unc_fire, cor_set, cor_clr;
   logic [31:0] rdata_q;
   logic init_q;

   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // lowest set bit index, used for the first error pointer
   function automatic logic [4:0] low_bit(input logic [31:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) r = 5'(i);
      end
      return r;
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction

   // severity: read-only bits forced to zero by the write mask
   // sticky writable fatal bits
   assign sev_en = bus.wr && hit(bus.addr, aer_pkg::OFS_UNC_SEVERITY);
   assign sev_d = bus.wdata & aer_pkg::SEV_WR_MASK;

   // severity kept in a power-on-only sticky word
   aer_sticky_reg u_sev (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .rst_val_i(aer_pkg::SEV_RESET),
      .d_i(sev_d),
      .en_i(sev_en),
      .q_o(sev_q)
   );

   // mask words and reset loading; masks are sticky as well,
   // so hot_reset_i leaves them alone
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         init_q <= 1'b0;
         cormask_q <= 32'h00000000;
         uncmask_q <= 32'h00000000;
      end else if (!init_q) begin
         init_q <= 1'b1;
         cormask_q <= aer_pkg::COR_MASK_RESET;
      end else if (bus.wr) begin
         if (hit(bus.addr, aer_pkg::OFS_COR_MASK)) begin
            cormask_q <= bus.wdata & aer_pkg::COR_WR_MASK;
         end
         if (hit(bus.addr, aer_pkg::OFS_UNC_MASK)) begin
            uncmask_q <= bus.wdata & aer_pkg::UNC_WR_MASK;
         end
      end
   end

   // correctable status: set wins over write-one-to-clear
   // every correctable event bit in COR_WR_MASK
   assign cor_set = cor_event_i & aer_pkg::COR_WR_MASK;
   assign cor_clr = (bus.wr && hit(bus.addr, aer_pkg::OFS_COR_STATUS)) ?
                    (bus.wdata & aer_pkg::COR_WR_MASK) : aer_pkg::ZERO_WORD;
   assign cor_d = (cor_q & ~cor_clr) | cor_set;

   // status cleared by power-on reset or write one, not by hot reset
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cor_q <= 32'h00000000;
      end else begin
         cor_q <= cor_d;
      end
   end

   // uncorrectable status: masking does not hide it
   // status set regardless of mask
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         uncst_q <= 32'h00000000;
      end else begin
         uncst_q <= (uncst_q & ~((bus.wr && hit(bus.addr, aer_pkg::OFS_UNC_STATUS)) ?
                     bus.wdata : aer_pkg::ZERO_WORD)) | (unc_event_i & aer_pkg::UNC_WR_MASK);
      end
   end

   assign unc_live = unc_event_i & aer_pkg::UNC_WR_MASK & ~uncmask_q;
   assign unc_fire = unc_live;

   // first error pointer, reloadable once its status bit is cleared
   // latch first reported bit
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ptr_q <= aer_pkg::PTR_RESET;
         ptr_valid_q <= 1'b0;
      end else if (!ptr_valid_q || !uncst_q[ptr_q]) begin
         if (unc_fire != aer_pkg::ZERO_WORD) begin
            ptr_q <= low_bit(unc_fire);
            ptr_valid_q <= 1'b1;
         end else begin
            ptr_valid_q <= 1'b0;
         end
      end
   end

   // reports; hot reset only quiets the pulses
   // severity selects class
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rep_q <= '{fatal: 1'b0, nonfatal: 1'b0, correctable: 1'b0};
      end else if (hot_reset_i) begin
         rep_q <= '{fatal: 1'b0, nonfatal: 1'b0, correctable: 1'b0};
      end else begin
         rep_q.fatal <= |(unc_fire & sev_q);
         rep_q.nonfatal <= |(unc_fire & ~sev_q);
         rep_q.correctable <= |(cor_set & ~cormask_q);
      end
   end

   // read data, valid the cycle after the strobe only
   // unmapped and reserved read zero
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= 32'h00000000;
      end else if (bus.rd) begin
         unique case (bus.addr)
            aer_pkg::OFS_UNC_SEVERITY: rdata_q <= sev_q & aer_pkg::SEV_WR_MASK;
            aer_pkg::OFS_COR_STATUS: rdata_q <= cor_q;
            aer_pkg::OFS_COR_MASK: rdata_q <= cormask_q;
            aer_pkg::OFS_UNC_MASK: rdata_q <= uncmask_q;
            aer_pkg::OFS_UNC_STATUS: rdata_q <= uncst_q;
            aer_pkg::OFS_ERR_CTRL: rdata_q <= {27'h0000000, ptr_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end else begin
         rdata_q <= 32'h00000000;
      end
   end

   assign rdata_o = rdata_q;
   assign rep_fatal_o = rep_q.fatal;
   assign rep_nonfatal_o = rep_q.nonfatal;
   assign rep_correctable_o = rep_q.correctable;

   // fatal pulse follows an unmasked event whose severity is one
   fatal_rep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (!hot_reset_i && |(unc_fire & sev_q)) |=> rep_fatal_o)
      else $error("fatal report missing");
   nonfatal_rep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (!hot_reset_i && |(unc_fire & ~sev_q)) |=> rep_nonfatal_o)
      else $error("non-fatal report missing");
   masked_quiet_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ((unc_event_i & ~uncmask_q & aer_pkg::UNC_WR_MASK) == 32'h00000000 &&
       cor_event_i == 32'h00000000) |=> !rep_fatal_o && !rep_nonfatal_o && !rep_correctable_o)
      else $error("report without unmasked event");
   ro_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      sev_q[15:14] == 2'h0)
      else $error("read-only severity bits not zero");
   cor_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cor_event_i[0] |=> cor_q[0])
      else $error("receiver error status not set");
   w1c_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (cor_clr[6] && !cor_set[6]) |=> !cor_q[6])
      else $error("write one did not clear");
   cor_mask_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (init_q && cor_event_i == 32'h00002000 && cormask_q[13]) |=>
      (cor_q[13] && !rep_correctable_o))
      else $error("masked correctable mishandled");
   ptr_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (ptr_valid_q && uncst_q[ptr_q] && !bus.wr) |=> $stable(ptr_q))
      else $error("first error pointer moved");
   rdata_idle_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !bus.rd |=> rdata_o == 32'h00000000)
      else $error("read data outside read cycle");
   abort_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      sev_q[15] == 1'b0)
      else $error("completer abort severity not zero");
   cor_rsvd_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (cor_q & ~aer_pkg::COR_WR_MASK) == 32'h00000000)
      else $error("reserved status bit set");
   bad_transaction_packet_flag_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cor_event_i[6] |=> cor_q[6])
      else $error("bad transaction packet status not set");
   badlink_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cor_event_i[7] |=> cor_q[7])
      else $error("bad link packet status not set");
   rollover_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cor_event_i[8] |=> cor_q[8])
      else $error("replay rollover status not set");
   replay_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cor_event_i[12] |=> cor_q[12])
      else $error("replay timer status not set");
   advisory_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cor_event_i[13] |=> cor_q[13])
      else $error("advisory status not set");
   // first unmasked event while no pointer is held
   sequence first_dl_fire;
      !ptr_valid_q && unc_fire[4];
   endsequence
   ptr_load_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      first_dl_fire |=> ptr_q == 5'h04)
      else $error("first error pointer not loaded");
   hot_quiet_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      hot_reset_i |=> !rep_fatal_o && !rep_nonfatal_o && !rep_correctable_o)
      else $error("report during hot reset");
endmodule

// *** aer_link_model.sv ***
// far side: link logic raising error events as one-cycle pulses
module aer_link_model (
   // clock
   input wire logic clk_i,
   // event pulses towards the error block
   output logic [31:0] unc_event_o,
   output logic [31:0] cor_event_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle with no event pending
   initial begin
      unc_event_o = 32'h0;
      cor_event_o = 32'h0;
   end

   // one event cycle, then quiet; gap lets the link stay idle longer
   task automatic fire(input logic [31:0] u, input logic [31:0] c, input int gap);
      @(posedge clk_i);
      unc_event_o <= u;
      cor_event_o <= c;
      @(posedge clk_i);
      unc_event_o <= 32'h0;
      cor_event_o <= 32'h0;
      repeat (gap) @(posedge clk_i);
   endtask
endmodule

// *** aer_severity_and_correctable_status_tb.sv ***
module aer_severity_and_correctable_status_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0, resetn_i = 1'b0, hot_reset_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [31:0] wdata_i = 32'h0, rdata_o, unc_event_i, cor_event_i, rv, w;
   logic rep_fatal_o, rep_nonfatal_o, rep_correctable_o;
   logic [31:0] sev, um, cm, cst;
   int fails = 0, check_count = 0, seed = 65083;

   // 10 MHz clock
   initial forever #50 clk_i = ~clk_i;

   aer_severity_and_correctable_status dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
      .hot_reset_i(hot_reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .unc_event_i(unc_event_i),
      .cor_event_i(cor_event_i), .rep_fatal_o(rep_fatal_o),
      .rep_nonfatal_o(rep_nonfatal_o), .rep_correctable_o(rep_correctable_o));

   aer_link_model model_u (.clk_i(clk_i), .unc_event_o(unc_event_i),
      .cor_event_o(cor_event_i));

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // one-cycle strobes, launched just after an edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rv = rdata_o;
      chk(n, e, rv);
   endtask

   task automatic end_of_test();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // power-on reset, first access launched on the third edge after release
   task automatic por();
      resetn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge clk_i);
   endtask

   // cut a hang short
   initial begin
      #3000000;
      fails++;
      end_of_test();
   end

   initial begin
      por();
      rchk("sev rst", 12'h10c, 32'h00062030);
      rchk("cor rst", 12'h110, 32'h0);
      rchk("unmapped", 12'h0f0, 32'h0);
      wr(12'h10c, 32'hffffffff);
      rchk("sev ones", 12'h10c, 32'h003f3031);
      $display("test registers done");
      cst = 32'h0;
      cm = 32'h00002000;
      for (int p = 0; p < 2; p++) begin
         sev = $random(seed);
         um = (p == 0) ? 32'h0 : $random(seed);
         wr(12'h10c, sev);
         wr(12'h104, um);
         sev = sev & 32'h003f3031;
         for (int b = 4; b < 22; b++) begin
            if (b inside {[6:11], 14, 15}) continue;
            model_u.fire(32'h1 << b, 32'h0, 0);
            #1;
            chk("fatal", 32'(!um[b] && sev[b]), 32'(rep_fatal_o));
            chk("nonfatal", 32'(!um[b] && !sev[b]), 32'(rep_nonfatal_o));
            repeat (p) @(posedge clk_i);
         end
         // pointer keeps the first reported bit while its status stands
         rchk("pointer", 12'h118, 32'h4);
         for (int b = 0; b < 14; b++) begin
            if (b inside {[1:5], [9:11]}) continue;
            model_u.fire(32'h0, 32'h1 << b, 0);
            #1;
            chk("correctable", 32'(!cm[b]), 32'(rep_correctable_o));
            cst[b] = 1'b1;
         end
         rchk("cor set", 12'h110, cst);
         wr(12'h110, 32'h0);
         rchk("cor zero w", 12'h110, cst);
         w = $random(seed);
         wr(12'h110, w);
         cst = cst & ~w;
         rchk("cor w1c", 12'h110, cst);
         cm = $random(seed);
         wr(12'h114, cm);
         $display("test events pass %0d done", p);
      end
      // hot reset leaves sticky state alone, power-on clears it
      @(posedge clk_i);
      hot_reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      hot_reset_i <= 1'b0;
      rchk("sev hot", 12'h10c, sev);
      rchk("cor hot", 12'h110, cst);
      por();
      rchk("sev por", 12'h10c, 32'h00062030);
      rchk("cor por", 12'h110, 32'h0);
      $display("test sticky done");
      end_of_test();
   end
endmodule
